/* File: hw/lcp_consts.vh */
/*
 * constants for the led current / pwm control block: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 mhz system clock and inclusion by bare name.
 */
// Notes on behaviour
// R1: host waits 1 ms after enable rise
// R2: engine timing scales with slow clock rate
// R3: four channels, 8-bit current and duty each
// R4: duty from engine or register; current register
// R5: three engines feed duty to mapped channels
// R6: current code linear, 100 uA per step
// R7: engines keep running without host accesses
// R8: current code resets to 17.5 mA default
// R9: duty 00 is off, ff always on, immediate
// R10: rate select bit picks 256 or 558 Hz
`ifndef LCP_CONSTS_VH
`define LCP_CONSTS_VH

// register offsets
`define LCP_REG_ENABLE    8'h00
`define LCP_REG_ENG_MODE  8'h01
`define LCP_REG_DUTY_B    8'h02
`define LCP_REG_DUTY_G    8'h03
`define LCP_REG_DUTY_R    8'h04
`define LCP_REG_CUR_B     8'h05
`define LCP_REG_CUR_G     8'h06
`define LCP_REG_CUR_R     8'h07
`define LCP_REG_CONFIG    8'h08
`define LCP_REG_LED_STATE 8'h0d
`define LCP_REG_DUTY_W    8'h0e
`define LCP_REG_CUR_W     8'h0f
`define LCP_REG_LED_MAP   8'h70

// field positions
`define LCP_BIT_CHIP_EN   6
`define LCP_BIT_RATE_SEL  6
`define LCP_BIT_INT_CLK   0

// reset values and the engine direct mode code
`define LCP_CUR_RESET     8'haf
`define LCP_ZERO_RESET    8'h00
`define LCP_DIRECT_MODE   2'h3

// timing
`define LCP_CLK_HZ        100000000
`define LCP_PWM_STEPS     256
`define LCP_PWM_LO_HZ     256
`define LCP_PWM_HI_HZ     558
`define LCP_PWM_DIV_LO    (`LCP_CLK_HZ / (`LCP_PWM_LO_HZ * `LCP_PWM_STEPS))
`define LCP_PWM_DIV_HI    (`LCP_CLK_HZ / (`LCP_PWM_HI_HZ * `LCP_PWM_STEPS))
`define LCP_SLOW_HZ_X10   327
`define LCP_SLOW_DIV      ((`LCP_CLK_HZ * 10) / `LCP_SLOW_HZ_X10)

// serial bus device address, low two bits from the select pins
`define LCP_DEV_ADDR_HI   5'h06

`endif

/* File: hw/lcp_pwm_chan.v */
/*
 * one led output channel: picks its duty source and compares it with
 * the shared pwm step count.
 * assumes the step count and engine duties are on the same clock.
 */
`timescale 1ns/100ps
`include "lcp_consts.vh"

module lcp_pwm_chan (
   input  wire        clock_in,
   input  wire        sys_rst_in,
   input  wire        enable_in,     // chip enabled
   input  wire [1:0]  map_sel_in,    // 0 register, 1..3 engine
   input  wire [7:0]  reg_duty_in,   // directly written duty
   input  wire [23:0] eng_duty_in,   // engine 1 in [23:16] .. 3 in [7:0]
   input  wire [7:0]  step_in,       // shared pwm step count
   output reg         pwm_out
);

   reg [7:0] duty;                   // selected duty

   // duty source select
   always @* begin
      case (map_sel_in)
         2'h0: duty = reg_duty_in;        // R4
         2'h1: duty = eng_duty_in[23:16]; // R4
         2'h2: duty = eng_duty_in[15:8];
         default: duty = eng_duty_in[7:0];
      endcase
   end

   // compare; full scale forced on so ff really means 100 percent
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= enable_in & ((duty == 8'hff) | (step_in < duty)); // R9
      end
   end

endmodule

/* File: hw/lcp_ctrl.v */
/*
 * led current / pwm control top: serial bus register slave, register
 * file, pwm step generator, engine time base and four output channels.
 * assumes scl, sda, enable and the slow clock are async
 * pins; engine duties come from the engine core on clock_in.
 */
`timescale 1ns/100ps
`include "lcp_consts.vh"

module lcp_ctrl (
   input  wire        clock_in,
   input  wire        sys_rst_in,
   input  wire        en_in,                 // enable pin
   input  wire [1:0]  addr_sel_in,           // address select pins
   input  wire        scl_in,                // serial bus clock
   input  wire        sda_in,                // serial bus data level
   input  wire        external_slow_clock,   // slow time base pin
   input  wire [23:0] eng_duty_in,           // engine 1..3 duties
   output reg         sda_out,               // always low when driven
   output reg         sda_oe_out,            // high pulls sda low
   output reg  [3:0]  pwm_out,               // b, g, r, w
   output reg  [31:0] led_current_out,       // w,r,g,b codes, 0.1 mA/lsb
   output reg  [5:0]  eng_mode_out,          // engine mode bits
   output reg         engine_tick_out        // one-cycle time base pulse
);

   localparam integer DIV_LO   = `LCP_PWM_DIV_LO;
   localparam integer DIV_HI   = `LCP_PWM_DIV_HI;
   localparam integer SLOW_DIV = `LCP_SLOW_DIV;

   localparam [2:0] S_IDLE = 3'h0;   // bus states
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_AACK = 3'h2;
   localparam [2:0] S_WR   = 3'h3;
   localparam [2:0] S_WACK = 3'h4;
   localparam [2:0] S_RD   = 3'h5;
   localparam [2:0] S_RACK = 3'h6;

   // pin synchronisers; first stage feeds only the second
   reg [1:0]  scl_sy_r, sda_sy_r, en_sy_r, slow_sy_r;
   reg        scl_p_r, sda_p_r, slow_p_r;  // previous synced values

   // register file
   reg [7:0]  enable_r;              // chip enable in bit 6
   reg [7:0]  config_r;              // rate select, clock select
   reg [7:0]  map_r;                 // two source bits per channel
   reg [7:0]  duty_r [0:3];          // direct duties b, g, r, w
   reg [7:0]  cur_r  [0:3];          // current codes b, g, r, w

   // bus engine
   reg [2:0]  st_r;
   reg [3:0]  bit_r;                 // bits of the current byte
   reg [7:0]  sh_r;                  // shift register
   reg [7:0]  ptr_r;                 // register pointer
   reg        rw_r;                  // read transfer
   reg        first_r;               // next byte is the pointer
   reg        ack_ok_r;              // host acked the read byte

   // pwm and time base
   reg [10:0] div_r;                 // pwm step divider
   reg [7:0]  step_r;                // pwm step count
   reg [11:0] slow_div_r;            // internal slow time base

   reg [7:0]  rdata;                 // read mux
   wire       rst = sys_rst_in | ~en_sy_r[1]; // enable low clears all but the synchronisers and previous-value flops
   wire       scl_rise = scl_sy_r[1] & ~scl_p_r;
   wire       scl_fall = ~scl_sy_r[1] & scl_p_r;
   wire       bus_start = scl_sy_r[1] & sda_p_r & ~sda_sy_r[1];
   wire       bus_stop  = scl_sy_r[1] & ~sda_p_r & sda_sy_r[1];
   wire [7:0] byte_in = {sh_r[6:0], sda_sy_r[1]};
   wire       wr_en = (st_r == S_WR) & scl_rise & (bit_r == 4'h7)
                      & ~first_r;
   wire       chip_on = enable_r[`LCP_BIT_CHIP_EN];
   wire [7:0] eng_b = (eng_mode_out[5:4] == `LCP_DIRECT_MODE)
                      ? duty_r[0] : eng_duty_in[23:16];
   wire [7:0] eng_g = (eng_mode_out[3:2] == `LCP_DIRECT_MODE)
                      ? duty_r[1] : eng_duty_in[15:8];
   wire [7:0] eng_r = (eng_mode_out[1:0] == `LCP_DIRECT_MODE)
                      ? duty_r[2] : eng_duty_in[7:0];
   wire [23:0] eng_duty = {eng_b, eng_g, eng_r}; // R5
   wire [3:0]  pwm_nxt;              // channel outputs

   // synchronisers and previous-value flops
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         scl_sy_r  <= 2'h3;
         sda_sy_r  <= 2'h3;
         en_sy_r   <= 2'h0;
         slow_sy_r <= 2'h0;
         scl_p_r   <= 1'b1;
         sda_p_r   <= 1'b1;
         slow_p_r  <= 1'b0;
      end else begin
         scl_sy_r  <= {scl_sy_r[0], scl_in};
         sda_sy_r  <= {sda_sy_r[0], sda_in};
         en_sy_r   <= {en_sy_r[0], en_in};
         slow_sy_r <= {slow_sy_r[0], external_slow_clock};
         scl_p_r   <= scl_sy_r[1];
         sda_p_r   <= sda_sy_r[1];
         slow_p_r  <= slow_sy_r[1];
      end
   end

   // read mux, address chain
   always @* begin
      if (ptr_r == `LCP_REG_ENABLE) begin
         rdata = enable_r;
      end else if (ptr_r == `LCP_REG_ENG_MODE) begin
         rdata = {2'h0, eng_mode_out};
      end else if (ptr_r == `LCP_REG_DUTY_B) begin
         rdata = duty_r[0];
      end else if (ptr_r == `LCP_REG_DUTY_G) begin
         rdata = duty_r[1];
      end else if (ptr_r == `LCP_REG_DUTY_R) begin
         rdata = duty_r[2];
      end else if (ptr_r == `LCP_REG_DUTY_W) begin
         rdata = duty_r[3];
      end else if (ptr_r == `LCP_REG_CUR_B) begin
         rdata = cur_r[0];
      end else if (ptr_r == `LCP_REG_CUR_G) begin
         rdata = cur_r[1];
      end else if (ptr_r == `LCP_REG_CUR_R) begin
         rdata = cur_r[2];
      end else if (ptr_r == `LCP_REG_CUR_W) begin
         rdata = cur_r[3];
      end else if (ptr_r == `LCP_REG_CONFIG) begin
         rdata = config_r;
      end else if (ptr_r == `LCP_REG_LED_MAP) begin
         rdata = map_r;
      end else if (ptr_r == `LCP_REG_LED_STATE) begin
         rdata = {4'h0, pwm_out};    // live output levels
      end else begin
         rdata = 8'h00;              // unmapped reads zero
      end
   end

   // register writes; unmapped writes are dropped
   always @(posedge clock_in) begin
      if (rst) begin
         enable_r     <= `LCP_ZERO_RESET;
         config_r     <= `LCP_ZERO_RESET;
         map_r        <= `LCP_ZERO_RESET;
         eng_mode_out <= 6'h00;
         duty_r[0] <= `LCP_ZERO_RESET;
         duty_r[1] <= `LCP_ZERO_RESET;
         duty_r[2] <= `LCP_ZERO_RESET;
         duty_r[3] <= `LCP_ZERO_RESET;
         cur_r[0]  <= `LCP_CUR_RESET; // R8
         cur_r[1]  <= `LCP_CUR_RESET;
         cur_r[2]  <= `LCP_CUR_RESET;
         cur_r[3]  <= `LCP_CUR_RESET;
      end else if (wr_en) begin
         if (ptr_r == `LCP_REG_ENABLE) begin
            enable_r <= byte_in;
         end else if (ptr_r == `LCP_REG_ENG_MODE) begin
            eng_mode_out <= byte_in[5:0];
         end else if (ptr_r == `LCP_REG_DUTY_B) begin
            duty_r[0] <= byte_in;    // R9
         end else if (ptr_r == `LCP_REG_DUTY_G) begin
            duty_r[1] <= byte_in;
         end else if (ptr_r == `LCP_REG_DUTY_R) begin
            duty_r[2] <= byte_in;
         end else if (ptr_r == `LCP_REG_DUTY_W) begin
            duty_r[3] <= byte_in;
         end else if (ptr_r == `LCP_REG_CUR_B) begin
            cur_r[0] <= byte_in;     // R6
         end else if (ptr_r == `LCP_REG_CUR_G) begin
            cur_r[1] <= byte_in;
         end else if (ptr_r == `LCP_REG_CUR_R) begin
            cur_r[2] <= byte_in;
         end else if (ptr_r == `LCP_REG_CUR_W) begin
            cur_r[3] <= byte_in;
         end else if (ptr_r == `LCP_REG_CONFIG) begin
            config_r <= byte_in;
         end else if (ptr_r == `LCP_REG_LED_MAP) begin
            map_r <= byte_in;
         end
      end
   end

   // current codes straight out to the sinks, always from registers
   always @(posedge clock_in) begin
      if (rst) begin
         led_current_out <= {4{`LCP_CUR_RESET}};
      end else begin
         led_current_out <= {cur_r[3], cur_r[2], cur_r[1], cur_r[0]}; // R4
      end
   end

   // serial bus slave; start and stop win over any bit activity
   always @(posedge clock_in) begin
      if (rst) begin
         st_r       <= S_IDLE;
         bit_r      <= 4'h0;
         sh_r       <= 8'h00;
         ptr_r      <= 8'h00;
         rw_r       <= 1'b0;
         first_r    <= 1'b0;
         ack_ok_r   <= 1'b0;
         sda_out    <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (bus_start) begin
         st_r       <= S_ADDR;
         bit_r      <= 4'h0;
         sda_oe_out <= 1'b0;
      end else if (bus_stop) begin
         st_r       <= S_IDLE;
         sda_oe_out <= 1'b0;
      end else begin
         case (st_r)
            S_ADDR: if (scl_rise) begin
               sh_r  <= byte_in;
               bit_r <= bit_r + 4'h1;
               if (bit_r == 4'h7) begin
                  rw_r <= sda_sy_r[1];
                  // not our address: ignore until next start
                  if (sh_r[6:0] == {`LCP_DEV_ADDR_HI, addr_sel_in}) begin
                     st_r <= S_AACK;
                  end else begin
                     st_r <= S_IDLE;
                  end
               end
            end
            S_AACK, S_WACK: if (scl_fall) begin
               if (!sda_oe_out) begin
                  sda_oe_out <= 1'b1;          // drive the ack low
               end else if (rw_r && st_r == S_AACK) begin
                  st_r       <= S_RD;          // first read bit now
                  bit_r      <= 4'h0;
                  sh_r       <= {rdata[6:0], 1'b0};
                  sda_oe_out <= ~rdata[7];
                  ptr_r      <= ptr_r + 8'h01;
               end else begin
                  st_r       <= S_WR;
                  bit_r      <= 4'h0;
                  first_r    <= (st_r == S_AACK);
                  sda_oe_out <= 1'b0;
               end
            end
            S_WR: if (scl_rise) begin
               sh_r  <= byte_in;
               bit_r <= bit_r + 4'h1;
               if (bit_r == 4'h7) begin
                  st_r <= S_WACK;
                  if (first_r) begin
                     ptr_r <= byte_in;         // pointer byte
                  end else begin
                     ptr_r <= ptr_r + 8'h01;   // auto increment
                  end
               end
            end
            S_RD: if (scl_rise) begin
               bit_r <= bit_r + 4'h1;
               if (bit_r == 4'h7) begin
                  st_r <= S_RACK;
               end
            end else if (scl_fall) begin
               sda_oe_out <= ~sh_r[7];
               sh_r       <= {sh_r[6:0], 1'b0};
            end
            S_RACK: if (scl_fall) begin
               // count the fall, not the line: a last bit of 1 leaves
               // oe low and must not skip the host's ack slot
               if (bit_r == 4'h8) begin
                  sda_oe_out <= 1'b0;          // release after last bit
                  bit_r      <= 4'h9;
               end else if (ack_ok_r) begin
                  st_r       <= S_RD;          // host wants more
                  bit_r      <= 4'h0;
                  sh_r       <= {rdata[6:0], 1'b0};
                  sda_oe_out <= ~rdata[7];
                  ptr_r      <= ptr_r + 8'h01;
               end else begin
                  st_r <= S_IDLE;              // nack ends the read
               end
            end else if (scl_rise) begin
               ack_ok_r <= ~sda_sy_r[1];
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // pwm step generator, rate from config
   always @(posedge clock_in) begin
      if (rst) begin
         div_r  <= 11'h000;
         step_r <= 8'h00;
      end else if ((config_r[`LCP_BIT_RATE_SEL] &&
                    div_r >= DIV_HI[10:0] - 11'h001) ||
                   div_r >= DIV_LO[10:0] - 11'h001) begin // R10
         div_r  <= 11'h000;
         step_r <= step_r + 8'h01;
      end else begin
         div_r  <= div_r + 11'h001;
      end
   end

   // engine time base; runs with no bus traffic at all
   always @(posedge clock_in) begin
      if (rst) begin
         slow_div_r      <= 12'h000;
         engine_tick_out <= 1'b0;
      end else if (config_r[`LCP_BIT_INT_CLK]) begin
         // internal divider, SLOW_DIV cut to 12 bits: one tick per 2487 clocks
         if (slow_div_r >= SLOW_DIV[11:0] - 12'h001) begin
            slow_div_r      <= 12'h000;
            engine_tick_out <= 1'b1;    // R7
         end else begin
            slow_div_r      <= slow_div_r + 12'h001;
            engine_tick_out <= 1'b0;
         end
      end else begin
         // one tick per slow clock rising edge, so rate follows the pin
         slow_div_r      <= 12'h000;
         engine_tick_out <= slow_sy_r[1] & ~slow_p_r; // R2
      end
   end

   // four channels; r3 gives each its own duty source and current
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
         lcp_pwm_chan u_chan (
            .clock_in    (clock_in),
            .sys_rst_in  (rst),
            .enable_in   (chip_on),
            .map_sel_in  (map_r[2*gi+1:2*gi]),
            .reg_duty_in (duty_r[gi]),
            .eng_duty_in (eng_duty),
            .step_in     (step_r),
            .pwm_out     (pwm_nxt[gi])
         ); // R3
      end
   endgenerate

   // retime channel outputs so the top ports come from flops here
   always @(posedge clock_in) begin
      if (rst) begin
         pwm_out <= 4'h0;
      end else begin
         pwm_out <= pwm_nxt;
      end
   end

endmodule

/* File: verif/lcp_ctrl_assertions.sv */
/*
 * checker for lcp_ctrl: reset values, time base pulses and bus answer.
 * assumes the internal time base is never selected by the bench.
 */
`timescale 1ns/100ps

module lcp_ctrl_assertions (
   input wire        clock_in,
   input wire        sys_rst_in,
   input wire        en_in,
   input wire [1:0]  addr_sel_in,
   input wire        scl_in,
   input wire        sda_in,
   input wire        external_slow_clock,
   input wire [23:0] eng_duty_in,
   input wire        sda_out,
   input wire        sda_oe_out,
   input wire [3:0]  pwm_out,
   input wire [31:0] led_current_out,
   input wire [5:0]  eng_mode_out,
   input wire        engine_tick_out
);
   // one domain; a low enable pin also clears state
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in || !en_in);

   chk_cur_release: assert property (
      $fell(sys_rst_in) |-> led_current_out == 32'hafafafaf)
      else $error("current codes wrong after reset");
   chk_idle_release: assert property (
      $fell(sys_rst_in) |-> pwm_out == 4'h0 && eng_mode_out == 6'h00
      && !sda_oe_out)
      else $error("outputs not idle after reset");
   chk_en_default: assert property (
      $rose(en_in) |-> led_current_out == 32'hafafafaf && pwm_out == 4'h0)
      else $error("enable rise without default state");
   chk_tick_follows: assert property (
      $rose(external_slow_clock) |-> ##[1:5] engine_tick_out)
      else $error("no time base pulse after slow edge");
   chk_tick_pulse: assert property (
      engine_tick_out |=> !engine_tick_out)
      else $error("time base pulse longer than one cycle");
   chk_tick_cause: assert property (
      engine_tick_out |-> external_slow_clock)
      else $error("time base pulse without slow clock high");
   chk_cur_on_scl: assert property (
      $changed(led_current_out) |-> scl_in)
      else $error("current code changed outside a bus bit");
   chk_ack_scl_low: assert property (
      $rose(sda_oe_out) |-> !scl_in)
      else $error("data line pulled while bus clock high");
   chk_sda_low: assert property (
      sda_out == 1'b0)
      else $error("data output not low");
endmodule

bind lcp_ctrl lcp_ctrl_assertions lcp_ctrl_assertions_inst (
   .clock_in(clock_in), .sys_rst_in(sys_rst_in), .en_in(en_in),
   .addr_sel_in(addr_sel_in), .scl_in(scl_in), .sda_in(sda_in),
   .external_slow_clock(external_slow_clock), .eng_duty_in(eng_duty_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .pwm_out(pwm_out),
   .led_current_out(led_current_out), .eng_mode_out(eng_mode_out),
   .engine_tick_out(engine_tick_out));

/* File: verif/lcp_host_model.sv */
/*
 * two-wire bus host model: start, stop, bit and byte tasks.
 * assumes a pull-up on the data wire, level fed back on sda_in.
 */
`timescale 1ns/100ps

module lcp_host_model #(
   parameter int QTR = 63   // quarter bit in clocks, keeps scl under 400 khz
) (
   input  wire  clock_in,
   input  wire  sda_in,     // resolved wire level
   output logic scl_out,    // bus clock, idles high
   output logic sda_pull_out // high pulls data low
);
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end

   task automatic qwait;
      repeat (QTR) @(posedge clock_in);
   endtask

   // no transfer until the device has started up
   task automatic power_up_wait;
      repeat (100000) @(posedge clock_in);
   endtask

   // also serves as repeated start from a low clock
   task automatic start_c;
      sda_pull_out <= 1'b0;
      qwait;
      scl_out <= 1'b1;
      qwait;
      sda_pull_out <= 1'b1;
      qwait;
      scl_out <= 1'b0;
      qwait;
   endtask

   task automatic stop_c;
      sda_pull_out <= 1'b1;
      qwait;
      scl_out <= 1'b1;
      qwait;
      sda_pull_out <= 1'b0;
      qwait;
   endtask

   // data set while clock low, sampled mid high phase
   task automatic bit_c(input logic b, output logic r);
      sda_pull_out <= !b;
      qwait;
      scl_out <= 1'b1;
      qwait;
      r = sda_in;
      qwait;
      scl_out <= 1'b0;
      qwait;
   endtask

   // msb first, then the ninth bit; last=1 releases it
   task automatic byte_c(input logic [7:0] d, input logic last,
                         output logic [7:0] r, output logic nak);
      for (int i = 7; i >= 0; i--) bit_c(d[i], r[i]);
      bit_c(last, nak);
   endtask
endmodule

/* File: verif/testbench.sv */
/*
 * self-checking bench for lcp_ctrl driven through the bus host model.
 * assumes select pins 2, so the device answers at 7'h1a.
 */
`timescale 1ns/100ps

module testbench;
   logic        clock_in;
   logic        sys_rst_in;
   logic        en_in;
   logic        slow_clk;   // external time base
   logic [23:0] eng_duty;   // engine 1..3 duties
   logic        scl;
   logic        host_pull;
   wire         sda_oe;
   wire         sda_w = !(host_pull || sda_oe); // pull-up wire
   wire  [3:0]  pwm;
   wire  [31:0] cur;
   wire  [5:0]  mode;
   wire         tick;
   int          failures = 0;
   int          checks = 0;
   int          ticks = 0;
   int          t0;
   logic [23:0] q;
   logic        nk;

   lcp_host_model host_inst (.clock_in(clock_in), .sda_in(sda_w),
      .scl_out(scl), .sda_pull_out(host_pull));

   lcp_ctrl lcp_ctrl_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .en_in(en_in), .addr_sel_in(2'h2), .scl_in(scl), .sda_in(sda_w),
      .external_slow_clock(slow_clk), .eng_duty_in(eng_duty),
      .sda_out(), .sda_oe_out(sda_oe), .pwm_out(pwm),
      .led_current_out(cur), .eng_mode_out(mode), .engine_tick_out(tick));

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = !clock_in;
   end

   // time base pulses seen
   always @(posedge clock_in) if (tick === 1'b1) ticks <= ticks + 1;

   task automatic give_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // pointer then n data bytes, msb byte of d first
   task automatic wr(input logic [6:0] dv, input logic [7:0] p,
                     input int n, input logic [23:0] d, output logic nak);
      logic [7:0] r;
      logic       a;
      host_inst.start_c();
      host_inst.byte_c({dv, 1'b0}, 1'b1, r, nak);
      host_inst.byte_c(p, 1'b1, r, a);
      nak = nak | a;
      for (int k = 0; k < n; k++) begin
         host_inst.byte_c(d[23-8*k -: 8], 1'b1, r, a);
         nak = nak | a;
      end
      host_inst.stop_c();
   endtask

   // pointer write, repeated start, n bytes read, nack on the last
   task automatic rd(input logic [7:0] p, input int n,
                     output logic [23:0] qo);
      logic [7:0] r;
      logic       a;
      qo = 24'h0;
      host_inst.start_c();
      host_inst.byte_c(8'h34, 1'b1, r, a);
      host_inst.byte_c(p, 1'b1, r, a);
      host_inst.start_c();
      host_inst.byte_c(8'h35, 1'b1, r, a);
      for (int k = 0; k < n; k++) begin
         host_inst.byte_c(8'hff, k == n - 1, r, a);
         qo = {qo[15:0], r};
      end
      host_inst.stop_c();
   endtask

   task automatic slow_run(input int half, input int n);
      repeat (n) begin
         slow_clk <= 1'b1;
         repeat (half) @(posedge clock_in);
         slow_clk <= 1'b0;
         repeat (half) @(posedge clock_in);
      end
   endtask

   task automatic settle;
      repeat (800) @(posedge clock_in); // shorter than one pwm step
   endtask

   initial begin
      sys_rst_in = 1'b1;
      en_in = 1'b1;
      slow_clk = 1'b0;
      eng_duty = 24'h0;
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      cmp(cur, 32'hafafafaf);
      host_inst.power_up_wait();
      // auto-increment across three current codes, boundary values
      wr(7'h1a, 8'h05, 3, 24'h00ff01, nk);
      wr(7'h1a, 8'h0f, 1, 24'hfe0000, nk);
      cmp(nk, 1'b0);
      cmp(cur, 32'hfe01ff00);
      rd(8'h05, 3, q);
      cmp(q, 24'h00ff01);
      // chip on, direct duties b=ff g=00 r=ff
      wr(7'h1a, 8'h00, 1, 24'h400000, nk);
      wr(7'h1a, 8'h02, 3, 24'hff00ff, nk);
      settle;
      cmp(pwm, 4'h5);
      // w reg, r eng1, g eng2, b eng3
      eng_duty <= 24'h00ffff;
      wr(7'h1a, 8'h70, 1, 24'h1b0000, nk);
      settle;
      cmp(pwm, 4'h3);
      eng_duty <= 24'hff0000; // no bus access before the next check
      settle;
      cmp(pwm, 4'h4);
      // engine 1 direct: duty comes from b duty register
      eng_duty <= 24'h000000;
      wr(7'h1a, 8'h01, 1, 24'h300000, nk);
      settle;
      cmp(pwm, 4'h4);
      cmp(mode, 6'h30);
      rd(8'h20, 1, q);
      cmp(q, 24'h0);
      wr(7'h1b, 8'h05, 1, 24'h110000, nk);
      cmp(nk, 1'b1);
      cmp(cur, 32'hfe01ff00);
      // twice the slow rate gives twice the pulses in one span
      t0 = ticks;
      slow_run(1500, 2);
      repeat (8) @(posedge clock_in);
      cmp(ticks - t0, 2);
      t0 = ticks;
      slow_run(750, 4);
      repeat (8) @(posedge clock_in);
      cmp(ticks - t0, 4);
      en_in <= 1'b0;
      repeat (6) @(posedge clock_in);
      en_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      cmp(cur, 32'hafafafaf);
      cmp(pwm, 4'h0);
      give_verdict;
   end

   // bench should end near 2.0 ms
   initial begin
      #3000000;
      failures++;
      give_verdict;
   end
endmodule
